//--- logic/wake_and_switch_status_bank.sv
// wake source, input level and high-side switch status bank behind a serial port
// ************************************************************************
// ************************************************************************
`timescale 1ns/10ps
`default_nettype none

module wake_and_switch_status_bank
   import status_bank_pkg::*;
(
   input wire logic mclk,
   input wire logic srst,
   input wire logic ce,
   input wire logic restart,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic mosi,
   output logic sdo,
   output logic sdo_oe,
   input wire logic bus_supply_uv_detect,
   input wire logic transceiver_mode_bit,
   input wire logic bus_wake,
   input wire logic timer_wake,
   input wire logic [2:0] wake_input_wake,
   input wire logic [1:0] pin_wake,
   input wire logic [3:0] switch_overload,
   input wire logic [3:0] switch_open_load,
   input wire logic [1:0] gpio_pin,
   input wire logic [2:0] wake_input_pin,
   input wire logic fail_output_test_pin,
   input wire logic pullup_sense_pin,
   input wire logic supply_marginal,
   input wire logic mode_normal_or_stop,
   input wire logic [1:0] pin_cfg_active,
   input wire logic [1:0] pin_is_gpio,
   input wire logic cyclic_sense,
   input wire logic sample_strobe,
   output logic bus_supply_undervoltage,
   output logic overload_suspect
);

   // ********************************************************************
   // input synchronisers
   // ********************************************************************
   logic [SYNC_W-1:0] async_in;
   logic [SYNC_W-1:0] sync_out;

   assign async_in = {supply_marginal, pullup_sense_pin, fail_output_test_pin,
                      wake_input_pin, gpio_pin, switch_open_load, switch_overload,
                      pin_wake, wake_input_wake, timer_wake, bus_wake,
                      bus_supply_uv_detect};

   genvar g;
   generate
      for (g = 0; g < SYNC_W; g++) begin : g_sync
         logic s1;
         logic s2;
         always_ff @(posedge mclk) begin
            if (srst) begin
               s1 <= 1'b0;
               s2 <= 1'b0;
            end else if (ce) begin
               s1 <= async_in[g];
               s2 <= s1;
            end
         end
         assign sync_out[g] = s2;
      end
   endgenerate

   wire logic uv_seen = sync_out[SYN_BUS_UV];
   wire logic bus_wake_seen = sync_out[SYN_BUS_WAKE];
   wire logic timer_wake_seen = sync_out[SYN_TIMER_WAKE];
   wire logic [2:0] wk_wake_seen = sync_out[SYN_WK_WAKE +: 3];
   wire logic [1:0] pin_wake_seen = sync_out[SYN_PIN_WAKE +: 2];
   wire logic [3:0] overload_seen = sync_out[SYN_OVERLOAD +: 4];
   wire logic [3:0] open_load_seen = sync_out[SYN_OPEN_LOAD +: 4];
   wire logic [1:0] pin_level_seen = sync_out[SYN_PIN_LVL +: 2];
   wire logic [2:0] wk_level_seen = sync_out[SYN_WK_LVL +: 3];
   wire logic development_mode_level = sync_out[SYN_DEV_MODE];
   wire logic pullup_config_status = sync_out[SYN_PULLUP];
   wire logic marginal_seen = sync_out[SYN_MARGINAL];

   // ********************************************************************
   // link side: frame counting and command capture on the serial clock
   // ********************************************************************
   logic [4:0] bit_cnt;
   logic [14:0] shift_in;
   logic [15:0] cmd_word;
   logic req_tgl;

   // chip select idle clears the frame state, as the link clock may stop
   always_ff @(posedge sclk or posedge cs_n) begin
      if (cs_n) begin
         bit_cnt <= 5'h00;
         shift_in <= 15'h0000;
      end else begin
         if (bit_cnt != FRAME_BITS)
            bit_cnt <= bit_cnt + 5'h01;
         shift_in <= {shift_in[13:0], mosi};
      end
   end

   // command and its toggle survive chip select so the core can pick them up
   always_ff @(posedge sclk or posedge srst) begin
      if (srst) begin
         cmd_word <= 16'h0000;
         req_tgl <= 1'b0;
      end else if (!cs_n && bit_cnt == LAST_EDGE) begin
         cmd_word <= {shift_in, mosi};
         req_tgl <= ~req_tgl;
      end
   end

   // ********************************************************************
   // crossing: toggle into the core clock; command word stands still meanwhile
   // ********************************************************************
   logic req_s1;
   logic req_s2;
   logic req_s3;

   always_ff @(posedge mclk) begin
      if (srst) begin
         req_s1 <= 1'b0;
         req_s2 <= 1'b0;
         req_s3 <= 1'b0;
      end else if (ce) begin
         req_s1 <= req_tgl;
         req_s2 <= req_s1;
         req_s3 <= req_s2;
      end
   end

   wire logic req_pulse = ce & (req_s2 ^ req_s3);
   wire logic cmd_clear = cmd_word[CMD_CLEAR_BIT];
   wire logic [6:0] cmd_addr = cmd_word[CMD_ADDR_MSB:CMD_ADDR_LSB];

   // ********************************************************************
   // address decode
   // ********************************************************************
   wire logic hit_wake_a = cmd_addr == ADDR_WAKE_A;
   wire logic hit_wake_b = cmd_addr == ADDR_WAKE_B;
   wire logic hit_level = cmd_addr == ADDR_LEVEL;
   wire logic hit_overload = cmd_addr == ADDR_OVERLOAD;
   wire logic hit_open_load = cmd_addr == ADDR_OPEN_LOAD;

   // ********************************************************************
   // sticky flag registers
   // ********************************************************************
   logic [7:0] wake_source_status_a;
   logic [7:0] wake_source_status_b;
   logic [7:0] high_side_overload_status;
   logic [7:0] high_side_open_load_status;

   // sources are not gated by mode, so a fail-safe wake lands here too
   wire logic [7:0] set_wake_a = {2'b00, bus_wake_seen, timer_wake_seen, 1'b0,
                                  wk_wake_seen};
   wire logic [7:0] set_wake_b = {2'b00, pin_wake_seen, 4'h0};
   wire logic [7:0] set_overload = {4'h0, overload_seen};
   wire logic [7:0] set_open_load = {4'h0, open_load_seen};

   // only bits captured into this command's answer are cleared; a new event is never lost
   wire logic clr_go = req_pulse & cmd_clear;
   wire logic [7:0] clr_wake_a = (clr_go && hit_wake_a) ? wake_source_status_a : 8'h00;
   wire logic [7:0] clr_wake_b = (clr_go && hit_wake_b) ? wake_source_status_b : 8'h00;
   wire logic [7:0] clr_overload = (clr_go && hit_overload) ?
                                   high_side_overload_status : 8'h00;
   wire logic [7:0] clr_open_load = (clr_go && hit_open_load) ?
                                    high_side_open_load_status : 8'h00;

   // restart keeps the flags and only forces the reserved bits low
   wire logic [7:0] hold_wake_a = restart ? KEEP_WAKE_A : ~clr_wake_a;
   wire logic [7:0] hold_wake_b = restart ? KEEP_WAKE_B : ~clr_wake_b;
   wire logic [7:0] hold_overload = restart ? KEEP_SWITCH : ~clr_overload;
   wire logic [7:0] hold_open_load = restart ? KEEP_SWITCH : ~clr_open_load;

   // set wins over clear; masks keep reserved bits at zero
   wire logic [7:0] next_wake_a = ((wake_source_status_a & hold_wake_a) | set_wake_a)
                                  & FLAGS_WAKE_A;
   wire logic [7:0] next_wake_b = ((wake_source_status_b & hold_wake_b) | set_wake_b)
                                  & FLAGS_WAKE_B;
   wire logic [7:0] next_overload = ((high_side_overload_status & hold_overload)
                                    | set_overload) & FLAGS_SWITCH;
   wire logic [7:0] next_open_load = ((high_side_open_load_status & hold_open_load)
                                     | set_open_load) & FLAGS_SWITCH;

   always_ff @(posedge mclk) begin
      if (srst) begin
         wake_source_status_a <= RESET_FLAGS;
         wake_source_status_b <= RESET_FLAGS;
         high_side_overload_status <= RESET_FLAGS;
         high_side_open_load_status <= RESET_FLAGS;
      end else if (ce) begin
         wake_source_status_a <= next_wake_a;
         wake_source_status_b <= next_wake_b;
         high_side_overload_status <= next_overload;
         high_side_open_load_status <= next_open_load;
      end
   end

   // ********************************************************************
   // input level register
   // ********************************************************************
   logic [1:0] pin_level;
   logic [2:0] wake_level_held;
   logic wake_sampled;

   // general-purpose selection shows the pad even when it drives a switch
   wire logic [1:0] pin_upd = ({2{mode_normal_or_stop}} & pin_cfg_active)
                              | pin_is_gpio;
   // pins have no sampling path: they follow the pad or hold, never the strobe
   wire logic [1:0] next_pin_level = (pin_upd & pin_level_seen)
                                     | (~pin_upd & pin_level);
   // until the first cyclic sample nothing is held, so the live level shows
   wire logic [2:0] wake_level_shown = (cyclic_sense & wake_sampled) ? wake_level_held
                                       : wk_level_seen;

   always_ff @(posedge mclk) begin
      if (srst) begin
         pin_level <= 2'b00;
         wake_level_held <= wk_level_seen;
         wake_sampled <= 1'b0;
      end else if (ce) begin
         pin_level <= next_pin_level;
         if (sample_strobe) begin
            wake_level_held <= wk_level_seen;
            wake_sampled <= 1'b1;
         end
      end
   end

   wire logic [7:0] input_level_status = {development_mode_level, pullup_config_status,
                                          pin_level, 1'b0,
                                          wake_level_shown};

   // ********************************************************************
   // read multiplexer and answer registers
   // ********************************************************************
   wire logic [7:0] read_val = hit_wake_a ? wake_source_status_a :
                               hit_wake_b ? wake_source_status_b :
                               hit_level ? input_level_status :
                               hit_overload ? high_side_overload_status :
                               hit_open_load ? high_side_open_load_status : READ_NONE;

   logic [7:0] resp_data;
   logic [6:0] resp_addr;
   logic resp_clear;

   always_ff @(posedge mclk) begin
      if (srst) begin
         resp_data <= 8'h00;
         resp_addr <= 7'h00;
         resp_clear <= 1'b0;
      end else if (req_pulse) begin
         resp_data <= read_val;
         resp_addr <= cmd_addr;
         resp_clear <= cmd_clear;
      end
   end

   // ********************************************************************
   // serial answer: previous frame's result, held still between frames
   // ********************************************************************
   // limitation: the host must idle chip select long enough for the core
   // to load the answer, otherwise the word may change mid-frame
   wire logic [15:0] resp_word = {resp_clear, resp_addr, resp_data};
   wire logic [3:0] sdo_idx = LAST_BIT - bit_cnt[3:0];

   assign sdo = ~bit_cnt[4] & resp_word[sdo_idx];
   assign sdo_oe = ~cs_n;

   // ********************************************************************
   // supply-related outputs
   // ********************************************************************
   always_ff @(posedge mclk) begin
      if (srst) begin
         bus_supply_undervoltage <= 1'b0;
         overload_suspect <= 1'b0;
      end else if (ce) begin
         bus_supply_undervoltage <= uv_seen & transceiver_mode_bit;
         overload_suspect <= marginal_seen
                             & (|high_side_overload_status);
      end
   end

endmodule // wake_and_switch_status_bank

`default_nettype wire

//--- common/status_bank_pkg.sv
// constants shared by the wake and switch status bank
package status_bank_pkg;

   // ********************************************************************
   // register addresses (7-bit serial address)
   // ********************************************************************
   localparam logic [6:0] ADDR_WAKE_A = 7'h46;
   localparam logic [6:0] ADDR_WAKE_B = 7'h47;
   localparam logic [6:0] ADDR_LEVEL = 7'h48;
   localparam logic [6:0] ADDR_OVERLOAD = 7'h54;
   localparam logic [6:0] ADDR_OPEN_LOAD = 7'h55;

   // ********************************************************************
   // field masks, reset and restart values
   // ********************************************************************
   localparam logic [7:0] FLAGS_WAKE_A = 8'h37;
   localparam logic [7:0] FLAGS_WAKE_B = 8'h30;
   localparam logic [7:0] FLAGS_SWITCH = 8'h0F;
   localparam logic [7:0] RESET_FLAGS = 8'h00;
   localparam logic [7:0] KEEP_WAKE_A = 8'h37;
   localparam logic [7:0] KEEP_WAKE_B = 8'h30;
   localparam logic [7:0] KEEP_SWITCH = 8'h0F;
   localparam logic [7:0] READ_NONE = 8'h00;

   // ********************************************************************
   // serial frame layout
   // ********************************************************************
   localparam logic [4:0] FRAME_BITS = 5'h10;
   localparam logic [4:0] LAST_EDGE = 5'h0F;
   localparam logic [3:0] LAST_BIT = 4'hF;
   localparam int CMD_CLEAR_BIT = 15;
   localparam int CMD_ADDR_MSB = 14;
   localparam int CMD_ADDR_LSB = 8;

   // ********************************************************************
   // positions of asynchronous inputs in the synchroniser vector
   // ********************************************************************
   localparam int SYN_BUS_UV = 0;
   localparam int SYN_BUS_WAKE = 1;
   localparam int SYN_TIMER_WAKE = 2;
   localparam int SYN_WK_WAKE = 3;
   localparam int SYN_PIN_WAKE = 6;
   localparam int SYN_OVERLOAD = 8;
   localparam int SYN_OPEN_LOAD = 12;
   localparam int SYN_PIN_LVL = 16;
   localparam int SYN_WK_LVL = 18;
   localparam int SYN_DEV_MODE = 21;
   localparam int SYN_PULLUP = 22;
   localparam int SYN_MARGINAL = 23;
   localparam int SYNC_W = 24;

endpackage

//--- verif/status_bank_chk.sv
// port assertions for the wake and switch status bank
`timescale 1ns/10ps
`default_nettype none
module status_bank_chk
   import status_bank_pkg::*;
(
   input wire logic mclk,
   input wire logic srst,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic sdo,
   input wire logic bus_supply_uv_detect,
   input wire logic transceiver_mode_bit,
   input wire logic supply_marginal,
   input wire logic bus_supply_undervoltage,
   input wire logic overload_suspect
);
   // ********
   // frame position and address of the answer being shifted out
   // ********
   logic [4:0] cnt;
   logic [7:0] sh;
   logic [6:0] adr;
   wire logic [6:0] cur_adr = (cnt == 5'h08) ? sh[6:0] : adr;
   wire logic [7:0] resv = (cur_adr == ADDR_WAKE_A) ? ~FLAGS_WAKE_A :
      (cur_adr == ADDR_WAKE_B) ? ~FLAGS_WAKE_B : (cur_adr == ADDR_LEVEL) ? 8'h08 :
      ((cur_adr == ADDR_OVERLOAD) || (cur_adr == ADDR_OPEN_LOAD)) ? ~FLAGS_SWITCH : 8'hFF;
   // chip select high restarts the count, matching the bit counter
   always_ff @(posedge sclk or posedge cs_n) begin
      if (cs_n) begin
         cnt <= 5'h00;
         sh <= 8'h00;
         adr <= 7'h00;
      end else begin
         cnt <= cnt + 5'h01;
         sh <= {sh[6:0], sdo};
         if (cnt == 5'h08) adr <= sh[6:0];
      end
   end
   property p_reserved;
      @(posedge sclk) disable iff (srst)
      (!cs_n && cnt[4:3] == 2'b01 && resv[4'hF - cnt[3:0]]) |-> !sdo;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved bit set");
   property p_uv_gate;
      @(posedge mclk) disable iff (srst) bus_supply_undervoltage |-> $past(transceiver_mode_bit);
   endproperty
   a_uv_gate: assert property (p_uv_gate) else $error("uv without mode");
   property p_uv_mode_low;
      @(posedge mclk) disable iff (srst)
      $fell(transceiver_mode_bit) |=> !bus_supply_undervoltage [*2];
   endproperty
   a_uv_mode_low: assert property (p_uv_mode_low) else $error("uv after mode off");
   property p_uv_on;
      @(posedge mclk) disable iff (srst)
      (bus_supply_uv_detect && transceiver_mode_bit) [*5] |=> bus_supply_undervoltage;
   endproperty
   a_uv_on: assert property (p_uv_on) else $error("uv missed");
   property p_uv_clear;
      @(posedge mclk) disable iff (srst) !bus_supply_uv_detect [*5] |=> !bus_supply_undervoltage;
   endproperty
   a_uv_clear: assert property (p_uv_clear) else $error("uv without detect");
   property p_uv_src;
      @(posedge mclk) disable iff (srst) $rose(bus_supply_undervoltage) |->
      $past(bus_supply_uv_detect, 2) || $past(bus_supply_uv_detect, 3);
   endproperty
   a_uv_src: assert property (p_uv_src) else $error("uv rose alone");
   property p_sus_off;
      @(posedge mclk) disable iff (srst) !supply_marginal [*4] |=> !overload_suspect;
   endproperty
   a_sus_off: assert property (p_sus_off) else $error("suspect off band");
   property p_sus_src;
      @(posedge mclk) disable iff (srst) $rose(overload_suspect) |->
      $past(supply_marginal, 2) || $past(supply_marginal, 3);
   endproperty
   a_sus_src: assert property (p_sus_src) else $error("suspect rose alone");
endmodule // status_bank_chk
bind wake_and_switch_status_bank status_bank_chk status_bank_chk_i (.mclk(mclk), .srst(srst),
   .sclk(sclk), .cs_n(cs_n), .sdo(sdo), .bus_supply_uv_detect(bus_supply_uv_detect),
   .transceiver_mode_bit(transceiver_mode_bit), .supply_marginal(supply_marginal),
   .bus_supply_undervoltage(bus_supply_undervoltage), .overload_suspect(overload_suspect));
`default_nettype wire

//--- verif/host_master.sv
// serial master model of the host microcontroller
`timescale 1ns/10ps
`default_nettype none
module host_master (
   output logic sclk,
   output logic cs_n,
   output logic mosi,
   input wire logic sdo
);
   // idle levels follow the pin pulls: clock and data low, select high
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      mosi = 1'b0;
   end
   // one 16-bit word each way, msb first; the clock stands still outside frames
   task automatic frame(input logic [15:0] tx, output logic [15:0] rx);
      int k;
      cs_n = 1'b0;
      for (k = 15; k >= 0; k--) begin
         mosi = tx[k];
         #80;
         rx[k] = sdo;
         sclk = 1'b1;
         #80;
         sclk = 1'b0;
      end
      #80;
      cs_n = 1'b1;
      mosi = 1'b0;
   endtask
endmodule // host_master
`default_nettype wire

//--- verif/wake_and_switch_status_bank_test.sv
// self-checking bench for the wake and switch status bank
`timescale 1ns/10ps
`default_nettype none
module wake_and_switch_status_bank_test;
   import status_bank_pkg::*;
   // ********
   // stimulus, model state and counters
   // ********
   logic mclk = 1'b0, srst = 1'b1, ce = 1'b1, restart = 1'b0, sample_strobe = 1'b0;
   logic bus_supply_uv_detect = 1'b0, transceiver_mode_bit = 1'b0, supply_marginal = 1'b0;
   logic bus_wake = 1'b0, timer_wake = 1'b0, fail_output_test_pin = 1'b1;
   logic pullup_sense_pin = 1'b1, mode_normal_or_stop = 1'b0, cyclic_sense = 1'b0;
   logic [2:0] wake_input_wake = 3'h0, wake_input_pin = 3'h5;
   logic [1:0] pin_wake = 2'h0, gpio_pin = 2'h3, pin_cfg_active = 2'h0, pin_is_gpio = 2'h0;
   logic [3:0] switch_overload = 4'h0, switch_open_load = 4'h0;
   wire logic sclk, cs_n, mosi, sdo, sdo_oe, bus_supply_undervoltage, overload_suspect;
   // a released data line reads high impedance (z), so a missing enable shows up
   wire logic sdo_w = sdo_oe ? sdo : 1'bz;
   logic [7:0] m_wa, m_wb, m_ol, m_olo;
   logic [1:0] m_pl;
   logic [2:0] m_wl;
   logic [15:0] rx;
   // answers still owed by the device, oldest first
   logic [15:0] pend_q [$];
   logic [6:0] addrs [6] = '{ADDR_WAKE_A, ADDR_WAKE_B, ADDR_LEVEL, ADDR_OVERLOAD,
      ADDR_OPEN_LOAD, 7'h49};
   int bad_count = 0, checks = 0, cyc = 0, i, j;
   integer seed = 16414;
   wake_and_switch_status_bank wake_and_switch_status_bank_i (
      .mclk, .srst, .ce, .restart, .sclk, .cs_n, .mosi, .sdo, .sdo_oe,
      .bus_supply_uv_detect, .transceiver_mode_bit, .bus_wake, .timer_wake,
      .wake_input_wake, .pin_wake, .switch_overload, .switch_open_load, .gpio_pin,
      .wake_input_pin, .fail_output_test_pin, .pullup_sense_pin, .supply_marginal,
      .mode_normal_or_stop, .pin_cfg_active, .pin_is_gpio, .cyclic_sense, .sample_strobe,
      .bus_supply_undervoltage, .overload_suspect);
   host_master host_master_i (.sclk, .cs_n, .mosi, .sdo(sdo_w));
   always #20 mclk = ~mclk;
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 20000) begin
         bad_count++;
         stop_test();
      end
   end
   task automatic stop_test();
      if (bad_count == 0 && checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic check(input logic [15:0] seen, input logic [15:0] want);
      checks++;
      if (seen !== want) begin
         bad_count++;
         $display("[FAIL] %0t seen %h want %h", $time, seen, want);
      end
   endtask
   function automatic logic [7:0] exp_data(input logic [6:0] a);
      case (a)
         ADDR_WAKE_A: return m_wa;
         ADDR_WAKE_B: return m_wb;
         ADDR_LEVEL: return {fail_output_test_pin, pullup_sense_pin, m_pl, 1'b0, m_wl};
         ADDR_OVERLOAD: return m_ol;
         ADDR_OPEN_LOAD: return m_olo;
         default: return 8'h00;
      endcase
   endfunction
   // the answer to each command only comes back in the following frame
   task automatic acc(input logic c, input logic [6:0] a);
      logic [7:0] d;
      logic [15:0] w;
      d = exp_data(a);
      @(posedge mclk);
      #13;
      host_master_i.frame({c, a, 8'h00}, rx);
      w = pend_q.pop_front();
      check(rx, w);
      pend_q.push_back({c, a, d});
      if (c && a == ADDR_WAKE_A) m_wa = 8'h00;
      if (c && a == ADDR_WAKE_B) m_wb = 8'h00;
      if (c && a == ADDR_OVERLOAD) m_ol = 8'h00;
      if (c && a == ADDR_OPEN_LOAD) m_olo = 8'h00;
      repeat (12) @(posedge mclk);
   endtask
   task automatic do_reset();
      srst <= 1'b1;
      {mode_normal_or_stop, pin_cfg_active, pin_is_gpio, cyclic_sense} <= 6'h00;
      repeat (12) @(posedge mclk);
      srst <= 1'b0;
      {m_wa, m_wb, m_ol, m_olo} = 32'h0;
      pend_q.delete();
      pend_q.push_back(16'h0000);
      m_pl = 2'h0;
      m_wl = wake_input_pin;
   endtask
   initial begin
      do_reset();
      for (j = 0; j < 6; j++) acc(1'b0, addrs[j]);
      for (i = 0; i < 10; i++) begin
         @(posedge mclk);
         {bus_wake, timer_wake, wake_input_wake, pin_wake} <= 7'($random(seed));
         {switch_overload, switch_open_load} <= 8'($random(seed));
         {gpio_pin, wake_input_pin, fail_output_test_pin, pullup_sense_pin} <= 7'($random(seed));
         {mode_normal_or_stop, pin_cfg_active, pin_is_gpio} <= 5'($random(seed));
         {bus_supply_uv_detect, transceiver_mode_bit, supply_marginal, restart} <=
            4'($random(seed));
         repeat (8) @(posedge mclk);
         #1;
         m_wa = m_wa | {2'b00, bus_wake, timer_wake, 1'b0, wake_input_wake};
         m_wb = m_wb | {2'b00, pin_wake, 4'h0};
         m_ol = m_ol | {4'h0, switch_overload};
         m_olo = m_olo | {4'h0, switch_open_load};
         for (j = 0; j < 2; j++)
            if ((mode_normal_or_stop && pin_cfg_active[j]) || pin_is_gpio[j])
               m_pl[j] = gpio_pin[j];
         m_wl = wake_input_pin;
         check(16'(bus_supply_undervoltage),
               16'(bus_supply_uv_detect & transceiver_mode_bit));
         check(16'(overload_suspect), 16'(supply_marginal & (m_ol != 8'h00)));
         @(posedge mclk);
         {bus_wake, timer_wake, wake_input_wake, pin_wake, restart} <= 8'h00;
         {switch_overload, switch_open_load} <= 8'h00;
         repeat (6) @(posedge mclk);
         for (j = 0; j < 6; j++) acc(1'($random(seed)), addrs[j]);
      end
      cyclic_sense <= 1'b1;
      for (j = 0; j < 3; j++) begin
         @(posedge mclk);
         wake_input_pin <= 3'(j * 3 + 1);
         repeat (4) @(posedge mclk);
         sample_strobe <= 1'b1;
         @(posedge mclk);
         sample_strobe <= 1'b0;
         wake_input_pin <= 3'(~(j * 3 + 1));
         m_wl = 3'(j * 3 + 1);
         repeat (4) @(posedge mclk);
         acc(1'b0, ADDR_LEVEL);
      end
      // clock enable low freezes the core, so a wake pulse in that time is never seen
      acc(1'b1, ADDR_WAKE_A);
      {ce, bus_wake} <= 2'b01;
      repeat (6) @(posedge mclk);
      {ce, bus_wake} <= 2'b10;
      repeat (6) @(posedge mclk);
      acc(1'b0, ADDR_WAKE_A);
      acc(1'b1, 7'h49);
      do_reset();
      // nothing sampled yet after reset, so cyclic mode still shows live levels
      cyclic_sense <= 1'b1;
      wake_input_pin <= 3'h6;
      m_wl = 3'h6;
      for (j = 0; j < 7; j++) acc(1'b0, addrs[j % 6]);
      stop_test();
   end
endmodule // wake_and_switch_status_bank_test
`default_nettype wire
